//--- dv/hbd_host_model.sv
`timescale 1ns/10ps
module hbd_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] dout,
    input  wire logic       oe_n,
    output logic      [7:0] din,
    output logic            rd_n,
    output logic            wr_n,
    output logic [2:0]      sel,
    output logic            cs_n,
    output logic            ack_n,
    output logic            tc
);
    logic [7:0] wd;
    logic [7:0] flt = 8'h5a;
    logic       drv;
    // A released wire toggles so a stale byte never looks valid
    assign din = !oe_n ? dout : (drv ? wd : flt);
    initial begin
        {rd_n, wr_n, cs_n, ack_n, drv} = 5'h1e;
        tc = 1'b0;
        sel = 3'h0;
        wd = 8'h00;
    end
    always @(posedge clk) flt <= ~flt;
    task dma(input logic a, input logic t);
        @(posedge clk);
        #1 ack_n = a;
        tc = t;
    endtask
    // Select flips after the leading edge to expose a late capture
    task access(input logic rd, input logic [2:0] s, input logic c,
                input logic [7:0] w, output logic [7:0] r, output logic o);
        @(posedge clk);
        #1 sel = s;
        cs_n = c;
        wd = w;
        drv = !rd;
        if (rd) rd_n = 1'b0;
        else wr_n = 1'b0;
        @(posedge clk);
        #1 sel = ~s;
        @(posedge clk);
        #1 r = din;
        o = oe_n;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(posedge clk);
        #1 drv = 1'b0;
        cs_n = 1'b1;
    endtask
endmodule

//--- dv/test_hbd_port.sv
`timescale 1ns/10ps
module test_hbd_port;
    logic clk, rst_n, chip_reset, rd_n, wr_n, cs_n, ack_n, tc, oe_n;
    logic req, irq, crdma, taken, wvalid, wready, want, last, fc, cirq, o;
    logic [7:0] din, dout, crd, r;
    logic [2:0] crs, sel;
    hbd_pkg::hbd_wr_entry_t went;
    int mismatches = 0;
    int checks_done = 0;
    int takes = 0;
    assign crd = {5'h14, crs};
    // Counts read pulses handed to the core
    always @(posedge clk) if (taken) takes <= takes + 1;
    hbd_host_model host (.clk(clk), .dout(dout), .oe_n(oe_n), .din(din), .rd_n(rd_n),
        .wr_n(wr_n), .sel(sel), .cs_n(cs_n), .ack_n(ack_n), .tc(tc));
    hbd_port DUT (.clk(clk), .rst_n(rst_n), .chip_reset(chip_reset),
        .host_data_lines_in(din), .host_data_lines_out(dout),
        .host_data_lines_oe_n(oe_n), .host_read_strobe_n(rd_n),
        .host_write_strobe_n(wr_n), .reg_select_lines(sel),
        .device_select_n(cs_n), .transfer_ack_n(ack_n), .transfer_final_count(tc),
        .transfer_request(req), .irq(irq), .core_rd_sel(crs), .core_rd_dma(crdma),
        .core_rd_data(crd), .core_rd_taken(taken), .core_wr_entry(went),
        .core_wr_valid(wvalid), .core_wr_ready(wready), .core_dma_want(want),
        .core_dma_last(last), .core_final_count(fc), .core_irq(cirq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bounded wait; a miss shows up in the following compare
    task wait_req;
        repeat (6) if (!req) @(posedge clk);
        #1 check(req, 1'b1);
    endtask
    task t_read;
        host.access(1'b1, 3'h2, 1'b0, 8'h00, r, o);
        check(o, 1'b0);
        check(r, 8'ha2);
        host.access(1'b1, 3'h7, 1'b0, 8'h00, r, o);
        check(r, 8'h03);
        host.access(1'b1, 3'h2, 1'b1, 8'h00, r, o);
        check(o, 1'b1);
        check(oe_n, 1'b1);
        check(16'(takes), 16'h0002);
    endtask
    // Core stalls: third write finds the buffer full and is lost
    task t_write;
        wready = 1'b0;
        for (int i = 0; i < 3; i++) host.access(1'b0, 3'(i), 1'b0, 8'h30 + 8'(i), r, o);
        #1 wready = 1'b1;
        for (int i = 0; i < 2; i++) begin
            check(went, {1'b0, 3'(i), 8'h30 + 8'(i)});
            @(posedge clk);
            #1;
        end
        check(wvalid, 1'b0);
        // Core stalled again so a wrongly queued byte stays visible
        wready = 1'b0;
        host.access(1'b0, 3'h3, 1'b1, 8'h77, r, o);
        @(posedge clk);
        #1 check(wvalid, 1'b0);
        wready = 1'b1;
    endtask
    task t_dma;
        want = 1'b1;
        wait_req();
        host.dma(1'b0, 1'b0);
        #1 check(crdma, 1'b1);
        host.access(1'b1, 3'h7, 1'b1, 8'h00, r, o);
        check(r, 8'ha7);
        host.dma(1'b1, 1'b0);
        last = 1'b1;
        wait_req();
        host.dma(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        #1 check(req, 1'b0);
        want = 1'b0;
        repeat (2) @(posedge clk);
        #1 want = 1'b1;
        wait_req();
        host.access(1'b1, 3'h0, 1'b1, 8'h00, r, o);
        check(req, 1'b0);
        // Still low with want held: the drop came at the read's fall
        @(posedge clk);
        #1 check(req, 1'b0);
        want = 1'b0;
        last = 1'b0;
        host.dma(1'b1, 1'b1);
        @(posedge clk);
        #1 check(fc, 1'b0);
        host.dma(1'b0, 1'b1);
        @(posedge clk);
        #1 check(fc, 1'b1);
        host.dma(1'b1, 1'b0);
        // Final count with ack low ends a non-last request
        want = 1'b1;
        wait_req();
        host.dma(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1 check(req, 1'b0);
        want = 1'b0;
        host.dma(1'b1, 1'b0);
    endtask
    task t_irq;
        cirq = 1'b1;
        repeat (2) @(posedge clk);
        #1 check(irq, 1'b1);
        host.access(1'b0, 3'h7, 1'b0, 8'h01, r, o);
        repeat (2) @(posedge clk);
        #1 check(irq, 1'b0);
        chip_reset = 1'b1;
        @(posedge clk);
        #1 chip_reset = 1'b0;
        host.access(1'b1, 3'h7, 1'b0, 8'h00, r, o);
        check(r, 8'h01);
        rst_n = 1'b0;
        @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 check(irq, 1'b1);
        cirq = 1'b0;
    endtask
    initial begin
        {rst_n, chip_reset, wready, want, last, cirq} = 6'h00;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        check(oe_n, 1'b1);
        check(req, 1'b0);
        repeat (2) @(posedge clk);
        t_read();
        t_write();
        t_dma();
        t_irq();
        conclude();
    end
endmodule

//--- logic/hbd_defines.svh
`ifndef HBD_DEFINES_SVH
`define HBD_DEFINES_SVH

// Data and select widths of the host port
`define HBD_DATA_W      8
`define HBD_SEL_W       3
// Write buffer depth
`define HBD_BUF_DEPTH   2
// Select code that addresses the port's own configuration byte
`define HBD_CFG_SEL     3'h7
// Configuration byte fields and reset value
`define HBD_CFG_DMA_BIT 0
`define HBD_CFG_IRQ_BIT 1
`define HBD_CFG_RESET   8'h03

`endif

//--- logic/hbd_pkg.sv
package hbd_pkg;

    // One host write, queued toward the controller core
    typedef struct packed {
        logic       dma;
        logic [2:0] sel;
        logic [7:0] data;
    } hbd_wr_entry_t;

    // DMA request sequencer, one-hot
    typedef enum logic [2:0] {
        HBD_DMA_IDLE = 3'b001,
        HBD_DMA_REQ  = 3'b010,
        HBD_DMA_DONE = 3'b100
    } hbd_dma_state_t;

endpackage

//--- logic/hbd_port.sv
`timescale 1ns/10ps
`include "hbd_defines.svh"

// Overview of operation
// - Eight-bit data bus released unless driving reads
// - Register select captured on leading strobe edge
// - Request output asks DMA for one byte
// - Last byte: drop request on ack/read fall
// - Low acknowledge enables DMA path, ignoring select
// - Final count accepted only while acknowledge low
// - Strobes ignored while device select and acknowledge both high
// - Interrupt request on its own output
// - Chip reset spares configuration byte
module hbd_port #(
    parameter int DATA_W    = `HBD_DATA_W,
    parameter int BUF_DEPTH = `HBD_BUF_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  chip_reset,
    input  wire logic [7:0]            host_data_lines_in,
    output logic      [7:0]            host_data_lines_out,
    output logic                       host_data_lines_oe_n,
    input  wire logic                  host_read_strobe_n,
    input  wire logic                  host_write_strobe_n,
    input  wire logic [2:0]            reg_select_lines,
    input  wire logic                  device_select_n,
    input  wire logic                  transfer_ack_n,
    input  wire logic                  transfer_final_count,
    output logic                       transfer_request,
    output logic                       irq,
    output logic [2:0]                 core_rd_sel,
    output logic                       core_rd_dma,
    input  wire logic [7:0]            core_rd_data,
    output logic                       core_rd_taken,
    output hbd_pkg::hbd_wr_entry_t     core_wr_entry,
    output logic                       core_wr_valid,
    input  wire logic                  core_wr_ready,
    input  wire logic                  core_dma_want,
    input  wire logic                  core_dma_last,
    output logic                       core_final_count,
    input  wire logic                  core_irq
);

    // Refused at elaboration: the pointers and the byte path are fixed in width
    if (DATA_W != 8) begin : g_width_check
        $error("hbd_port serves an eight-bit bus only");
    end
    if (BUF_DEPTH != 2) begin : g_depth_check
        $error("hbd_port buffer pointers assume depth 2");
    end

    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    logic rd_n_q;
    logic wr_n_q;
    logic ack_n_q;
    logic [2:0] sel_q;
    logic dma_acc_q;
    logic wr_qual_q;
    logic [7:0] dout_q;
    logic [7:0] cfg_q;
    logic irq_q;
    logic rd_taken_q;
    logic fc_q;
    hbd_pkg::hbd_dma_state_t dma_q;

    logic qual;
    logic rd_lead;
    logic wr_lead;
    logic wr_trail;
    logic ack_fall;
    logic buf_in_valid;
    logic buf_in_ready;
    hbd_pkg::hbd_wr_entry_t buf_in;

    // Strobes count only while low and qualified by select or ack
    assign qual     = ~device_select_n | ~transfer_ack_n;
    assign rd_lead  = fell(rd_n_q, host_read_strobe_n) & qual;
    assign wr_lead  = fell(wr_n_q, host_write_strobe_n) & qual;
    assign wr_trail = ~wr_n_q & host_write_strobe_n & wr_qual_q;
    assign ack_fall = fell(ack_n_q, transfer_ack_n);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            ack_n_q <= 1'b1;
        end else begin
            rd_n_q  <= host_read_strobe_n;
            wr_n_q  <= host_write_strobe_n;
            ack_n_q <= transfer_ack_n;
        end
    end

    // Select and path kind are frozen at the leading edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q     <= 3'h0;
            dma_acc_q <= 1'b0;
            wr_qual_q <= 1'b0;
        end else if (chip_reset) begin
            sel_q     <= 3'h0;
            dma_acc_q <= 1'b0;
            wr_qual_q <= 1'b0;
        end else begin
            if (rd_lead || wr_lead) begin
                sel_q     <= reg_select_lines;
                dma_acc_q <= ~transfer_ack_n;
            end
            if (wr_lead) begin
                wr_qual_q <= 1'b1;
            end else if (wr_trail) begin
                wr_qual_q <= 1'b0;
            end
        end
    end

    // Core sees the live select so read data can be latched at the edge
    assign core_rd_sel = reg_select_lines;
    assign core_rd_dma = ~transfer_ack_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q     <= 8'h00;
            rd_taken_q <= 1'b0;
        end else if (chip_reset) begin
            dout_q     <= 8'h00;
            rd_taken_q <= 1'b0;
        end else begin
            rd_taken_q <= rd_lead;
            if (rd_lead) begin
                dout_q <= (transfer_ack_n && reg_select_lines == `HBD_CFG_SEL) ?
                          cfg_q : core_rd_data;
            end
        end
    end
    assign core_rd_taken = rd_taken_q;

    // Bus driven only during a qualified read; low enable means driving
    assign host_data_lines_out  = dout_q;
    assign host_data_lines_oe_n = ~(~host_read_strobe_n & ~rd_n_q & qual);

    // Configuration byte survives chip reset, reloaded with 8'h03 only by rst_n
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `HBD_CFG_RESET;
        end else if (wr_trail && !dma_acc_q && sel_q == `HBD_CFG_SEL) begin
            cfg_q <= host_data_lines_in;
        end
    end

    // Write data sampled on the trailing edge, queued for the core
    assign buf_in_valid = wr_trail & (dma_acc_q | sel_q != `HBD_CFG_SEL);
    assign buf_in       = '{dma: dma_acc_q, sel: sel_q, data: host_data_lines_in};

    hbd_pkg::hbd_wr_entry_t buf_mem [BUF_DEPTH];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;

    assign buf_in_ready  = (cnt_q != 2'd2);
    assign core_wr_valid = (cnt_q != 2'd0);
    assign core_wr_entry = buf_mem[rp_q];

    // A full buffer cannot stall the host, so the request is held off instead
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else if (chip_reset) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (buf_in_valid && buf_in_ready) begin
                wp_q <= ~wp_q;
            end
            if (core_wr_valid && core_wr_ready) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'(buf_in_valid && buf_in_ready)
                           - 2'(core_wr_valid && core_wr_ready);
        end
    end

    always_ff @(posedge clk) begin
        if (buf_in_valid && buf_in_ready) begin
            buf_mem[wp_q] <= buf_in;
        end
    end

    // DMA request sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_q <= hbd_pkg::HBD_DMA_IDLE;
            fc_q  <= 1'b0;
        end else if (chip_reset) begin
            dma_q <= hbd_pkg::HBD_DMA_IDLE;
            fc_q  <= 1'b0;
        end else begin
            fc_q <= transfer_final_count & ~transfer_ack_n;
            unique case (dma_q)
                hbd_pkg::HBD_DMA_IDLE: begin
                    if (core_dma_want && cfg_q[`HBD_CFG_DMA_BIT] && buf_in_ready) begin
                        dma_q <= hbd_pkg::HBD_DMA_REQ;
                    end
                end
                hbd_pkg::HBD_DMA_REQ: begin
                    if (transfer_final_count && !transfer_ack_n) begin
                        dma_q <= hbd_pkg::HBD_DMA_DONE;
                    end else if (core_dma_last && (ack_fall ||
                                 (!ack_n_q && fell(rd_n_q, host_read_strobe_n)))) begin
                        dma_q <= hbd_pkg::HBD_DMA_DONE;
                    end else if (!transfer_ack_n && (wr_trail ||
                                 (!rd_n_q && host_read_strobe_n))) begin
                        dma_q <= hbd_pkg::HBD_DMA_IDLE;
                    end
                end
                hbd_pkg::HBD_DMA_DONE: begin
                    if (!core_dma_want) begin
                        dma_q <= hbd_pkg::HBD_DMA_IDLE;
                    end
                end
                default: dma_q <= hbd_pkg::HBD_DMA_IDLE;
            endcase
        end
    end
    assign transfer_request = (dma_q == hbd_pkg::HBD_DMA_REQ);
    assign core_final_count = fc_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (chip_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_irq & cfg_q[`HBD_CFG_IRQ_BIT];
        end
    end
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || chip_reset);

    bus_release_a: assert property (host_read_strobe_n |-> host_data_lines_oe_n)
        else $error("data bus driven without read strobe");
    drive_qual_a: assert property (!host_data_lines_oe_n |-> qual)
        else $error("data bus driven without select or ack");
    sel_capture_a: assert property (rd_lead |=> sel_q == $past(reg_select_lines))
        else $error("select not captured at leading edge");
    unselected_a: assert property ((device_select_n && transfer_ack_n) |-> !rd_lead && !wr_lead)
        else $error("strobe taken while deselected");
    last_ack_drop_a: assert property ((transfer_request && core_dma_last && ack_fall)
        |=> !transfer_request)
        else $error("request kept after last-byte ack");
    demand_drop_a: assert property ((transfer_request && core_dma_last && !ack_n_q
        && fell(rd_n_q, host_read_strobe_n)) |=> !transfer_request)
        else $error("request kept after demand-mode read");
    fc_gate_a: assert property (core_final_count |-> $past(!transfer_ack_n))
        else $error("final count taken without ack");
    req_rise_a: assert property ($rose(transfer_request) |-> $past(core_dma_want)
        && $past(buf_in_ready))
        else $error("request raised without cause");
    irq_follow_a: assert property ((core_irq && cfg_q[`HBD_CFG_IRQ_BIT]) |=> irq)
        else $error("interrupt not forwarded");
    cfg_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        chip_reset |=> cfg_q == $past(cfg_q))
        else $error("configuration lost on chip reset");

    reg_read_c: cover property (rd_lead && !device_select_n);
    dma_write_c: cover property (wr_trail && dma_acc_q);
    buf_full_c: cover property (!buf_in_ready);
    last_byte_c: cover property (transfer_request ##1 dma_q == hbd_pkg::HBD_DMA_DONE);

endmodule
